// ---- core/rdc_cfg_if.sv ----
`timescale 1ns/1ns
interface rdc_cfg_if;
	// Host drive, enable low while driving
	logic left_side_config_pin_out;
	logic left_side_config_pin_oe_n;
	logic right_side_config_pin_out;
	logic right_side_config_pin_oe_n;
	// Pin level as seen through a weak pull-up and a weak pull-down
	logic left_side_config_pin_pu;
	logic left_side_config_pin_pd;
	logic right_side_config_pin_pu;
	logic right_side_config_pin_pd;

	assign left_side_config_pin_pu = left_side_config_pin_oe_n ? 1'b1 : left_side_config_pin_out;
	assign left_side_config_pin_pd = left_side_config_pin_oe_n ? 1'b0 : left_side_config_pin_out;
	assign right_side_config_pin_pu = right_side_config_pin_oe_n ? 1'b1 : right_side_config_pin_out;
	assign right_side_config_pin_pd = right_side_config_pin_oe_n ? 1'b0 : right_side_config_pin_out;

	modport host (
		output left_side_config_pin_out,
		output left_side_config_pin_oe_n,
		output right_side_config_pin_out,
		output right_side_config_pin_oe_n
	);

	modport device (
		input left_side_config_pin_pu,
		input left_side_config_pin_pd,
		input right_side_config_pin_pu,
		input right_side_config_pin_pd
	);
endinterface

// ---- core/rdc_device.sv ----
// Operation
// - Read each pin as high, low, open
// - Left pin sets A output, B equalization
// - High selects long profile
// - Open selects medium profile
// - Low, other not low, selects short
// - Right pin sets B output, A equalization
// - Enable low only when both pins low; code also holds it low in ST_OFF and in deep until 1 us after a pin reads high
// - Both low enters deep within 115 ms
// - Any pin high exits deep in 1 us
// - Settings applied 6 ms after exit
// - Later changes latched every 115 ms
// - Active carries data, termination indication held
// - Power-saving keeps channels, runs detection
// - State only from bus and pins
// - Deep opens all terminations
// - Host may request deep anytime
// - Unpowered device sees host low or tri-state
// - Transmitter reports far-end load present
// - Idle 300 ms before power-saving
// - Activity returns to active within 115 us
// - Termination detection within 6 ms of supply
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns
module rdc_device #(
	parameter int unsigned P_RCFG_CYC = rdc_pkg::RCFG_CYC,
	parameter int unsigned P_SETTLE_CYC = rdc_pkg::EXIT_SETTLE_CYC,
	parameter int unsigned P_STARTUP_CYC = rdc_pkg::STARTUP_CYC,
	parameter int unsigned P_IDLE_CYC = rdc_pkg::IDLE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration pins
	rdc_cfg_if.device cfg,
	// Bus electrical conditions
	input wire logic supply_valid,
	input wire logic bus_active,
	input wire logic far_end_load_present,
	// Profile and enable controls
	output logic chip_en_r,
	output logic [1:0] left_prof_r,
	output logic [1:0] right_prof_r,
	// Termination and channel controls
	output logic term_open_r,
	output logic term_det_en_r,
	output logic squelch_en_r,
	output logic chan_en_r,
	output logic term_present_r,
	// Power state
	output logic [1:0] pwr_state_r
);
	localparam int W = rdc_pkg::CNT_W;

	rdc_pkg::rdc_lvl_t left_lvl;
	rdc_pkg::rdc_lvl_t right_lvl;
	rdc_pkg::rdc_lvl_t left_app_r;
	rdc_pkg::rdc_lvl_t right_app_r;
	rdc_pkg::rdc_pwr_t st_r;
	rdc_pkg::rdc_pwr_t st_nxt;
	logic [W-1:0] tmr_r;
	logic [W-1:0] tmr_nxt;
	logic [W-1:0] per_r;
	logic [W-1:0] idle_r;
	logic settle_r;
	logic settle_nxt;

	rdc_tern_sampler u_left (
		.clk(clk),
		.rst_n(rst_n),
		.sense_pu(cfg.left_side_config_pin_pu),
		.sense_pd(cfg.left_side_config_pin_pd),
		.lvl_r(left_lvl)
	);

	rdc_tern_sampler u_right (
		.clk(clk),
		.rst_n(rst_n),
		.sense_pu(cfg.right_side_config_pin_pu),
		.sense_pd(cfg.right_side_config_pin_pd),
		.lvl_r(right_lvl)
	);

	// Pin decoding
	wire both_low = left_lvl == rdc_pkg::LVL_LOW && right_lvl == rdc_pkg::LVL_LOW;
	wire any_high = left_lvl == rdc_pkg::LVL_HIGH || right_lvl == rdc_pkg::LVL_HIGH;
	wire running = st_r == rdc_pkg::ST_SAVE || st_r == rdc_pkg::ST_ACTIVE;

	// Timer decoding
	wire startup_done = tmr_r == W'(P_STARTUP_CYC - 1);
	wire exit_done = tmr_r == W'(rdc_pkg::DEEP_EXIT_CYC - 1);
	wire settle_done = settle_r && tmr_r == W'(P_SETTLE_CYC - 1);
	wire per_tick = per_r == W'(P_RCFG_CYC - 1);
	wire idle_done = idle_r == W'(P_IDLE_CYC - 1);
	wire rcfg_tick = running && !settle_r && per_tick;

	// Pins are taken into the active settings only at these moments
	wire latch = (st_r == rdc_pkg::ST_OFF && supply_valid && startup_done) || settle_done || rcfg_tick;
	wire rdc_pkg::rdc_lvl_t left_app_nxt = latch ? left_lvl : left_app_r;
	wire rdc_pkg::rdc_lvl_t right_app_nxt = latch ? right_lvl : right_app_r;
	wire deep_req = latch && both_low;

	// Power state sequencing, driven by pins and bus conditions only
	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r + W'(1);
		settle_nxt = settle_r;
		unique case (st_r)
			rdc_pkg::ST_OFF: begin
				if (!supply_valid) begin
					tmr_nxt = '0;
				end else if (startup_done) begin
					tmr_nxt = '0;
					st_nxt = both_low ? rdc_pkg::ST_DEEP : rdc_pkg::ST_SAVE;
				end
			end
			rdc_pkg::ST_DEEP: begin
				if (!any_high) begin
					tmr_nxt = '0;
				end else if (exit_done) begin
					tmr_nxt = '0;
					settle_nxt = 1'b1;
					st_nxt = rdc_pkg::ST_ACTIVE;
				end
			end
			rdc_pkg::ST_SAVE: begin
				if (bus_active && far_end_load_present) begin
					st_nxt = rdc_pkg::ST_ACTIVE;
				end
			end
			rdc_pkg::ST_ACTIVE: begin
				if (!far_end_load_present || idle_done) begin
					st_nxt = rdc_pkg::ST_SAVE;
				end
			end
		endcase
		if (running && settle_done) begin
			settle_nxt = 1'b0;
		end
		if (running && deep_req) begin
			st_nxt = rdc_pkg::ST_DEEP;
			settle_nxt = 1'b0;
			tmr_nxt = '0;
		end
		if (!supply_valid) begin
			st_nxt = rdc_pkg::ST_OFF;
			settle_nxt = 1'b0;
		end
	end

	// Output decoding from the next state
	wire nxt_run = st_nxt == rdc_pkg::ST_SAVE || st_nxt == rdc_pkg::ST_ACTIVE;
	wire nxt_save = st_nxt == rdc_pkg::ST_SAVE;
	wire nxt_act = st_nxt == rdc_pkg::ST_ACTIVE;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= rdc_pkg::ST_OFF;
			tmr_r <= '0;
			settle_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			settle_r <= settle_nxt;
		end
	end

	// Reconfiguration period restarts whenever settings are taken on exit
	always_ff @(posedge clk) begin
		if (!rst_n || !running || settle_r || per_tick) begin
			per_r <= '0;
		end else begin
			per_r <= per_r + W'(1);
		end
	end

	// Idle time on the bus while active
	always_ff @(posedge clk) begin
		if (!rst_n || st_r != rdc_pkg::ST_ACTIVE || bus_active || idle_done) begin
			idle_r <= '0;
		end else begin
			idle_r <= idle_r + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			left_app_r <= rdc_pkg::LVL_RST;
			right_app_r <= rdc_pkg::LVL_RST;
		end else begin
			left_app_r <= left_app_nxt;
			right_app_r <= right_app_nxt;
		end
	end

	// Left code drives channel A swing and de-emphasis and channel B
	// equalization; right code the mirror image
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			left_prof_r <= rdc_pkg::PROF_MEDIUM;
			right_prof_r <= rdc_pkg::PROF_MEDIUM;
			chip_en_r <= 1'b0;
		end else begin
			left_prof_r <= rdc_pkg::profile(left_app_nxt);
			right_prof_r <= rdc_pkg::profile(right_app_nxt);
			chip_en_r <= nxt_run;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			term_open_r <= 1'b1;
			term_det_en_r <= 1'b0;
			squelch_en_r <= 1'b0;
			chan_en_r <= 1'b0;
			term_present_r <= 1'b0;
			pwr_state_r <= 2'(rdc_pkg::ST_OFF);
		end else begin
			term_open_r <= !nxt_run;
			term_det_en_r <= nxt_save;
			squelch_en_r <= nxt_save;
			chan_en_r <= nxt_run;
			term_present_r <= nxt_act || (nxt_save && far_end_load_present);
			pwr_state_r <= 2'(st_nxt);
		end
	end
endmodule

// ---- core/rdc_host.sv ----
`timescale 1ns/1ns
module rdc_host (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Device supply state
	input wire logic dev_powered,
	// Configuration pins
	rdc_cfg_if.host cfg
);
	logic [3:0] ctrl_r;

	wire setup = psel && !penable;
	wire access = psel && penable && pready;
	wire hit_ctrl = paddr == rdc_pkg::CTRL_OFS;
	wire hit_stat = paddr == rdc_pkg::STATUS_OFS;
	wire rdc_pkg::rdc_lvl_t left_req = rdc_pkg::code_to_lvl(ctrl_r[rdc_pkg::CTRL_LEFT_LSB +: 2]);
	wire rdc_pkg::rdc_lvl_t right_req = rdc_pkg::code_to_lvl(ctrl_r[rdc_pkg::CTRL_RIGHT_LSB +: 2]);
	wire deep_asked = left_req == rdc_pkg::LVL_LOW && right_req == rdc_pkg::LVL_LOW;
	wire [31:0] stat_word = 32'((6'(deep_asked) << rdc_pkg::STAT_DEEP_BIT)
		| (6'(right_req) << rdc_pkg::STAT_RIGHT_LSB)
		| (6'(left_req) << rdc_pkg::STAT_LEFT_LSB)
		| (6'(dev_powered) << rdc_pkg::STAT_PWR_BIT));
	wire [31:0] rd_word = hit_ctrl ? {28'h0000000, ctrl_r} : (hit_stat ? stat_word : 32'h0000_0000);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup && !hit_ctrl && !hit_stat;
			prdata <= setup && !pwrite ? rd_word : 32'h0000_0000;
		end
	end

	// Writes take effect at any time; final levels belong within 4 ms of a deep exit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_r <= rdc_pkg::CTRL_RST;
		end else if (access && pwrite && hit_ctrl) begin
			ctrl_r <= pwdata[3:0];
		end
	end

	// Unpowered device: pins released so no current flows into it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg.left_side_config_pin_out <= 1'b0;
			cfg.left_side_config_pin_oe_n <= 1'b1;
			cfg.right_side_config_pin_out <= 1'b0;
			cfg.right_side_config_pin_oe_n <= 1'b1;
		end else begin
			cfg.left_side_config_pin_out <= left_req == rdc_pkg::LVL_HIGH;
			cfg.left_side_config_pin_oe_n <= !dev_powered || left_req == rdc_pkg::LVL_OPEN;
			cfg.right_side_config_pin_out <= right_req == rdc_pkg::LVL_HIGH;
			cfg.right_side_config_pin_oe_n <= !dev_powered || right_req == rdc_pkg::LVL_OPEN;
		end
	end
endmodule

// ---- core/rdc_pkg.sv ----
package rdc_pkg;

	// Three-level pin reading
	typedef enum logic [1:0] {
		LVL_LOW,
		LVL_OPEN,
		LVL_HIGH
	} rdc_lvl_t;

	// Power states
	typedef enum logic [1:0] {
		ST_OFF,
		ST_DEEP,
		ST_SAVE,
		ST_ACTIVE
	} rdc_pwr_t;

	// Profile codes to the analog equalizer and driver controls
	localparam logic [1:0] PROF_SHORT = 2'h0;
	localparam logic [1:0] PROF_MEDIUM = 2'h1;
	localparam logic [1:0] PROF_LONG = 2'h2;

	// Reset values
	localparam rdc_lvl_t LVL_RST = LVL_OPEN;
	localparam logic [3:0] CTRL_RST = 4'h5;

	// Host register map (byte addresses)
	localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFS = 32'h0000_0004;

	// Host control and status fields
	localparam int CTRL_LEFT_LSB = 0;
	localparam int CTRL_RIGHT_LSB = 2;
	localparam int STAT_PWR_BIT = 0;
	localparam int STAT_LEFT_LSB = 1;
	localparam int STAT_RIGHT_LSB = 3;
	localparam int STAT_DEEP_BIT = 5;

	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1_000;
	localparam int STABLE_US = 1;
	localparam int STABLE_CYC = STABLE_US * CYC_PER_US;
	localparam int DEEP_EXIT_US = 1;
	localparam int DEEP_EXIT_CYC = DEEP_EXIT_US * CYC_PER_US;
	localparam int DEEP_ENTRY_MS = 115;
	localparam int DEEP_ENTRY_CYC = DEEP_ENTRY_MS * CYC_PER_MS;
	localparam int RCFG_MS = 115;
	localparam int RCFG_CYC = RCFG_MS * CYC_PER_MS;
	localparam int EXIT_SETTLE_MS = 6;
	localparam int EXIT_SETTLE_CYC = EXIT_SETTLE_MS * CYC_PER_MS;
	localparam int HOST_WINDOW_MS = 4;
	localparam int HOST_WINDOW_CYC = HOST_WINDOW_MS * CYC_PER_MS;
	localparam int STARTUP_MS = 6;
	localparam int STARTUP_CYC = STARTUP_MS * CYC_PER_MS;
	localparam int IDLE_MS = 300;
	localparam int IDLE_CYC = IDLE_MS * CYC_PER_MS;
	localparam int CNT_W = 25;

	// Pull-up and pull-down sense pair to a level
	function automatic rdc_lvl_t classify(input logic pu, input logic pd);
		if (pu && pd) begin
			return LVL_HIGH;
		end
		if (!pu && !pd) begin
			return LVL_LOW;
		end
		return LVL_OPEN;
	endfunction

	function automatic logic [1:0] profile(input rdc_lvl_t lvl);
		unique case (lvl)
			LVL_HIGH: return PROF_LONG;
			LVL_OPEN: return PROF_MEDIUM;
			default: return PROF_SHORT;
		endcase
	endfunction

	// Host field code to level; the unused code reads as open
	function automatic rdc_lvl_t code_to_lvl(input logic [1:0] code);
		unique case (code)
			2'h0: return LVL_LOW;
			2'h2: return LVL_HIGH;
			default: return LVL_OPEN;
		endcase
	endfunction

endpackage

// ---- core/rdc_tern_sampler.sv ----
`timescale 1ns/1ns
module rdc_tern_sampler (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sense pair
	input wire logic sense_pu,
	input wire logic sense_pd,
	// Filtered level
	output rdc_pkg::rdc_lvl_t lvl_r
);
	logic pu_s1_r;
	logic pu_s2_r;
	logic pd_s1_r;
	logic pd_s2_r;
	rdc_pkg::rdc_lvl_t cand_r;
	logic [5:0] cnt_r;

	wire rdc_pkg::rdc_lvl_t raw = rdc_pkg::classify(pu_s2_r, pd_s2_r);
	wire changed = raw != cand_r;
	wire stable = cnt_r == 6'(rdc_pkg::STABLE_CYC - 1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pu_s1_r <= 1'b1;
			pu_s2_r <= 1'b1;
			pd_s1_r <= 1'b0;
			pd_s2_r <= 1'b0;
			cand_r <= rdc_pkg::LVL_RST;
			cnt_r <= 6'h00;
			lvl_r <= rdc_pkg::LVL_RST;
		end else begin
			pu_s1_r <= sense_pu;
			pu_s2_r <= pu_s1_r;
			pd_s1_r <= sense_pd;
			pd_s2_r <= pd_s1_r;
			cand_r <= raw;
			if (changed) begin
				cnt_r <= 6'h00;
			end else if (stable) begin
				lvl_r <= cand_r;
			end else begin
				cnt_r <= cnt_r + 6'h01;
			end
		end
	end
endmodule

// ---- dv/rdc_monitor.sv ----
`timescale 1ns/1ns
module rdc_monitor #(
	parameter int P_RCFG_CYC = 400,
	parameter int P_IDLE_CYC = 500
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin signals
	input wire logic left_side_config_pin_pu,
	input wire logic left_side_config_pin_pd,
	input wire logic right_side_config_pin_pu,
	input wire logic right_side_config_pin_pd,
	input wire logic left_side_config_pin_oe_n,
	input wire logic right_side_config_pin_oe_n,
	// Conditions
	input wire logic supply_valid,
	input wire logic bus_active,
	input wire logic far_end_load_present,
	input wire logic dev_powered,
	// Device outputs
	input wire logic chip_en_r,
	input wire logic [1:0] left_prof_r,
	input wire logic [1:0] right_prof_r,
	input wire logic term_open_r,
	input wire logic term_det_en_r,
	input wire logic squelch_en_r,
	input wire logic chan_en_r,
	input wire logic term_present_r,
	input wire logic [1:0] pwr_state_r
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic [15:0] low_cnt_r;
	logic [15:0] idle_cnt_r;
	wire both_low = !left_side_config_pin_pu && !right_side_config_pin_pu;
	wire any_high = (left_side_config_pin_pu && left_side_config_pin_pd)
		|| (right_side_config_pin_pu && right_side_config_pin_pd);

	// Cycles with both pins low, and cycles active with an idle bus
	always_ff @(posedge clk) begin
		if (!rst_n || !both_low || !supply_valid) begin
			low_cnt_r <= 16'h0;
		end else if (low_cnt_r != 16'hFFFF) begin
			low_cnt_r <= low_cnt_r + 16'h1;
		end
		if (!rst_n || pwr_state_r != 2'h3 || bus_active) begin
			idle_cnt_r <= 16'h0;
		end else if (idle_cnt_r != 16'hFFFF) begin
			idle_cnt_r <= idle_cnt_r + 16'h1;
		end
	end

	deep_entry_a: assert property (low_cnt_r >= 16'(P_RCFG_CYC + 80) |-> pwr_state_r == 2'h1)
		else $error("deep entry late");
	deep_exit_a: assert property ($rose(any_high) && pwr_state_r == 2'h1 |-> ##[1:150] pwr_state_r == 2'h3)
		else $error("deep exit late");
	deep_out_a: assert property (pwr_state_r == 2'h1 ##1 pwr_state_r == 2'h1
		|-> term_open_r && !chip_en_r && !chan_en_r) else $error("deep outputs wrong");
	save_out_a: assert property (pwr_state_r == 2'h2 ##1 pwr_state_r == 2'h2
		|-> term_det_en_r && squelch_en_r && chan_en_r && chip_en_r) else $error("save outputs wrong");
	active_out_a: assert property (pwr_state_r == 2'h3 ##1 pwr_state_r == 2'h3
		|-> term_present_r && !term_det_en_r && chan_en_r && chip_en_r) else $error("active outputs wrong");
	prof_code_a: assert property (left_prof_r != 2'h3 && right_prof_r != 2'h3)
		else $error("bad profile code");
	prof_hold_a: assert property (pwr_state_r == 2'h1 && $past(pwr_state_r, 2) == 2'h1
		|-> $stable(left_prof_r) && $stable(right_prof_r)) else $error("profile moved in deep");
	bus_wake_a: assert property (pwr_state_r == 2'h2 && bus_active && far_end_load_present && !both_low
		|-> ##[1:3] pwr_state_r == 2'h3) else $error("wake late");
	idle_exit_a: assert property (pwr_state_r == 2'h3 |-> idle_cnt_r < 16'(P_IDLE_CYC + 4))
		else $error("idle exit late");
	host_rel_a: assert property ((!dev_powered) [*4] |-> left_side_config_pin_oe_n && right_side_config_pin_oe_n)
		else $error("pins driven while unpowered");
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
	localparam int RCFG = 400;
	localparam int IDLE = 500;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic dev_powered = 1'b1;
	logic supply_valid = 1'b0;
	logic bus_active = 1'b0;
	logic far_end_load_present = 1'b0;
	logic chip_en_r, term_open_r, term_det_en_r, squelch_en_r, chan_en_r, term_present_r;
	logic [1:0] left_prof_r, right_prof_r, pwr_state_r;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [31:0] d;
	int errors = 0;
	int num_checks = 0;
	int seed = 32'h884a;

	always #10 clk = ~clk;

	rdc_cfg_if u_rdc_cfg_if();
	rdc_host u_rdc_host(.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dev_powered(dev_powered), .cfg(u_rdc_cfg_if.host));
	rdc_device #(.P_RCFG_CYC(RCFG), .P_SETTLE_CYC(300), .P_STARTUP_CYC(200), .P_IDLE_CYC(IDLE)) u_rdc_device(
		.clk(clk), .rst_n(rst_n), .cfg(u_rdc_cfg_if.device), .supply_valid(supply_valid),
		.bus_active(bus_active), .far_end_load_present(far_end_load_present), .chip_en_r(chip_en_r),
		.left_prof_r(left_prof_r), .right_prof_r(right_prof_r), .term_open_r(term_open_r),
		.term_det_en_r(term_det_en_r), .squelch_en_r(squelch_en_r), .chan_en_r(chan_en_r),
		.term_present_r(term_present_r), .pwr_state_r(pwr_state_r));
	rdc_monitor #(.P_RCFG_CYC(RCFG), .P_IDLE_CYC(IDLE)) u_rdc_monitor(.clk(clk), .rst_n(rst_n),
		.left_side_config_pin_pu(u_rdc_cfg_if.left_side_config_pin_pu),
		.left_side_config_pin_pd(u_rdc_cfg_if.left_side_config_pin_pd),
		.right_side_config_pin_pu(u_rdc_cfg_if.right_side_config_pin_pu),
		.right_side_config_pin_pd(u_rdc_cfg_if.right_side_config_pin_pd),
		.left_side_config_pin_oe_n(u_rdc_cfg_if.left_side_config_pin_oe_n),
		.right_side_config_pin_oe_n(u_rdc_cfg_if.right_side_config_pin_oe_n),
		.supply_valid(supply_valid), .bus_active(bus_active), .far_end_load_present(far_end_load_present),
		.dev_powered(dev_powered), .chip_en_r(chip_en_r), .left_prof_r(left_prof_r), .right_prof_r(right_prof_r),
		.term_open_r(term_open_r), .term_det_en_r(term_det_en_r), .squelch_en_r(squelch_en_r),
		.chan_en_r(chan_en_r), .term_present_r(term_present_r), .pwr_state_r(pwr_state_r));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Expectation x: [33] read, [32] error, [31:0] read data
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd, input logic [33:0] x);
		int n;
		n = 0;
		exp_q.push_back(x);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin
			errors++;
			tally_and_finish();
		end
	endtask

	task automatic wait_st(input logic [1:0] s, input int lim);
		int n;
		n = 0;
		while (pwr_state_r !== s && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk({6'h0, pwr_state_r}, {6'h0, s});
		if (pwr_state_r !== s) begin
			tally_and_finish();
		end
	endtask

	// Answer checker: oldest note against each completed transfer
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			e = exp_q.pop_front();
			num_checks++;
			if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
				errors++;
				$display("mismatch at %0t got %h exp %h", $time, {pslverr, prdata}, e[32:0]);
			end
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		supply_valid <= 1'b1;
		apb(1'b0, 32'h0, 32'h0, 34'h2_0000_0005);
		apb(1'b0, 32'h8, 32'h0, 34'h3_0000_0000);
		apb(1'b1, 32'h4, 32'h0, 34'h0);
		wait_st(2'h2, 400);
		chk({4'h0, right_prof_r, left_prof_r}, 8'h5);
		$display("startup test done");
		for (int i = 1; i < 9; i++) begin
			d = $random(seed);
			d[3:0] = {2'(i / 3), 2'(i % 3)};
			apb(1'b1, 32'h0, d, 34'h0);
			apb(1'b0, 32'h4, 32'h0, {2'b10, 26'h0, 1'b0, d[3:0], 1'b1});
			repeat (RCFG + 120) @(posedge clk);
			chk({4'h0, right_prof_r, left_prof_r}, {4'h0, d[3:0]});
			chk({7'h0, chip_en_r}, 8'h1);
		end
		$display("pin table test done");
		apb(1'b1, 32'h0, 32'hF, 34'h0);
		apb(1'b0, 32'h4, 32'h0, 34'h2_0000_000B);
		apb(1'b1, 32'h0, 32'h0, 34'h0);
		wait_st(2'h1, RCFG + 100);
		chk({6'h0, term_open_r, chip_en_r}, 8'h2);
		apb(1'b0, 32'h4, 32'h0, 34'h2_0000_0021);
		repeat (RCFG) @(posedge clk);
		chk({6'h0, pwr_state_r}, 8'h1);
		far_end_load_present <= 1'b1;
		apb(1'b1, 32'h0, 32'h9, 34'h0);
		wait_st(2'h3, 150);
		chk({4'h0, right_prof_r, left_prof_r}, 8'h0);
		repeat (320) @(posedge clk);
		chk({4'h0, right_prof_r, left_prof_r}, 8'h9);
		chk({6'h0, pwr_state_r}, 8'h3);
		$display("deep test done");
		wait_st(2'h2, IDLE + 60);
		far_end_load_present <= 1'b0;
		repeat (3) @(posedge clk);
		chk({7'h0, term_present_r}, 8'h0);
		far_end_load_present <= 1'b1;
		repeat (3) @(posedge clk);
		chk({7'h0, term_present_r}, 8'h1);
		bus_active <= 1'b1;
		wait_st(2'h3, 4);
		far_end_load_present <= 1'b0;
		wait_st(2'h2, 4);
		$display("bus test done");
		dev_powered <= 1'b0;
		repeat (RCFG + 120) @(posedge clk);
		chk({4'h0, right_prof_r, left_prof_r}, 8'h5);
		dev_powered <= 1'b1;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({4'h0, pwr_state_r, chip_en_r, term_open_r}, 8'h1);
		apb(1'b0, 32'h0, 32'h0, 34'h2_0000_0005);
		$display("reset test done");
		tally_and_finish();
	end
endmodule
